// ==== design/sch_pkg.sv ====
// shared constants of the system control and status hub: register map,
// field positions, counts and reset values.
// assumes a 32-bit classic Wishbone slave with byte addresses on the bus.
package sch_pkg;

    // counts of attached controllers and sources
    localparam int NUM_DMA_PERIPH = 8;
    localparam int NUM_EMAC = 3;
    localparam int NUM_USB = 2;
    localparam int NUM_WD = 4;
    localparam int NUM_ECC = 11;
    localparam int NUM_HANDOFF = 8;
    localparam int HAUSER_W = 5;
    localparam int NUM_FPGA_IF = 9;
    localparam int ADDR_W = 8;

    // word indices (byte address = 4 * index)
    localparam logic [5:0] IDX_DMA = 6'h00;
    localparam logic [5:0] IDX_NAND_BOOT = 6'h01;
    localparam logic [5:0] IDX_FLASH_ATTR = 6'h02;
    localparam logic [5:0] IDX_EMAC_GLOBAL = 6'h03;
    localparam logic [5:0] IDX_EMAC0 = 6'h04;
    localparam logic [5:0] IDX_USB0 = 6'h07;
    localparam logic [5:0] IDX_CARD_ATTR = 6'h09;
    localparam logic [5:0] IDX_CARD_CLK = 6'h0A;
    localparam logic [5:0] IDX_WD_DEBUG = 6'h0B;
    localparam logic [5:0] IDX_FPGA_EN = 6'h0C;
    localparam logic [5:0] IDX_ECC_MASK = 6'h0D;
    localparam logic [5:0] NUM_CTRL = 6'h0E;
    localparam logic [5:0] IDX_ECC_SBE = 6'h0E;
    localparam logic [5:0] IDX_ECC_DBE = 6'h0F;
    localparam logic [5:0] IDX_HANDOFF = 6'h20;

    // dma word fields
    localparam int DMA_DMA_MANAGER_NONSECURE_BIT = 0;
    localparam int DMA_DMA_IRQ_NONSECURE_BIT = 1;
    localparam int DMA_PERIPH_LSB = 8;
    // nand bootstrap fields
    localparam int NAND_NOINIT_BIT = 0;
    localparam int NAND_SKIP_LOAD_BIT = 1;
    localparam int NAND_SMALL_PAGE_BIT = 2;
    localparam int NAND_TWO_ROW_BIT = 3;
    // flash master attribute fields
    localparam int FL_ARPROT_LSB = 0;
    localparam int FL_AWPROT_LSB = 3;
    localparam int FL_ARDOM_LSB = 6;
    localparam int FL_AWDOM_LSB = 8;
    localparam int FL_ARCACHE_LSB = 10;
    localparam int FL_AWCACHE_LSB = 14;
    // per-mac word fields
    localparam int EM_ARCACHE_LSB = 0;
    localparam int EM_AWCACHE_LSB = 4;
    localparam int EM_PHY_LSB = 8;
    localparam int EM_TSREF_BIT = 10;
    // ahb master attribute fields (usb and card)
    localparam int AHB_HPROT_LSB = 0;
    localparam int AHB_HAUSER_LSB = 4;
    // card clock phase fields
    localparam int CK_DRV_LSB = 0;
    localparam int CK_SMPL_LSB = 4;

    // writable bits per control word, everything else reads zero
    localparam logic [31:0] MASK_DMA = 32'h0000_FF03;
    localparam logic [31:0] MASK_NAND = 32'h0000_000F;
    localparam logic [31:0] MASK_FLASH = 32'h0003_FFFF;
    localparam logic [31:0] MASK_EGLOB = 32'h0000_0007;
    localparam logic [31:0] MASK_EMAC = 32'h0000_07FF;
    localparam logic [31:0] MASK_AHB = 32'h0000_01FF;
    localparam logic [31:0] MASK_CLK = 32'h0000_0077;
    localparam logic [31:0] MASK_WD = 32'h0000_000F;
    localparam logic [31:0] MASK_FPGA = 32'h0000_01FF;
    localparam logic [31:0] MASK_ECC = 32'h0000_07FF;
    localparam logic [31:0] RST_WORD = 32'h0000_0000;

    // writable-bit mask of a control word index
    function automatic logic [31:0] sch_ctrl_mask(input logic [5:0] idx);
        if (idx == IDX_DMA) return MASK_DMA;
        if (idx == IDX_NAND_BOOT) return MASK_NAND;
        if (idx == IDX_FLASH_ATTR) return MASK_FLASH;
        if (idx == IDX_EMAC_GLOBAL) return MASK_EGLOB;
        if (idx >= IDX_EMAC0 && idx < IDX_USB0) return MASK_EMAC;
        if (idx >= IDX_USB0 && idx <= IDX_CARD_ATTR) return MASK_AHB;
        if (idx == IDX_CARD_CLK) return MASK_CLK;
        if (idx == IDX_WD_DEBUG) return MASK_WD;
        if (idx == IDX_FPGA_EN) return MASK_FPGA;
        if (idx == IDX_ECC_MASK) return MASK_ECC;
        return RST_WORD;
    endfunction

    // byte-lane merge of write data into an old word
    function automatic logic [31:0] sch_merge(input logic [31:0] old_w,
                                             input logic [31:0] new_w,
                                             input logic [3:0] sel);
        logic [31:0] r;
        r = old_w;
        for (int b = 0; b < 4; b++) begin
            if (sel[b]) r[8*b +: 8] = new_w[8*b +: 8];
        end
        return r;
    endfunction

endpackage

// ==== design/sch_ecc_combine.sv ====
// combines per-source ecc error levels into status and two interrupts.
// assumes the sources hold their error level until cleared at the source.
module sch_ecc_combine #(
    parameter int N = sch_pkg::NUM_ECC
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic ce_i,
    input wire logic [N-1:0] sbe_i,
    input wire logic [N-1:0] dbe_i,
    input wire logic [N-1:0] sbe_mask_i,
    output logic [N-1:0] sbe_status_o,
    output logic [N-1:0] dbe_status_o,
    output logic serr_irq_o,
    output logic derr_irq_o
);
    logic serr_next;
    logic derr_next;

    // unmasked single-bit errors only; double-bit errors have no mask
    assign serr_next = |(sbe_i & ~sbe_mask_i);
    assign derr_next = |dbe_i;

    // status mirrors sources, no sticky bit: clearing is done at the source
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            sbe_status_o <= '0;
            dbe_status_o <= '0;
            serr_irq_o <= 1'b0;
            derr_irq_o <= 1'b0;
        end else if (ce_i) begin
            sbe_status_o <= sbe_i;
            dbe_status_o <= dbe_i;
            serr_irq_o <= serr_next;
            derr_irq_o <= derr_next;
        end
    end
endmodule // sch_ecc_combine

// ==== design/sch_top.sv ====
// system control and status hub: wishbone register bank driving side-band
// controls of dma, nand, emac, usb, card, watchdog and fpga interfaces.
// assumes all side-band inputs are synchronous to clk_i; rst_i is the
// warm-or-cold reset, cold_rst_i the cold-only reset, both synchronous.
module sch_top #(
    parameter int NUM_EMAC = sch_pkg::NUM_EMAC,
    parameter int NUM_USB = sch_pkg::NUM_USB,
    parameter int NUM_WD = sch_pkg::NUM_WD,
    parameter int NUM_ECC = sch_pkg::NUM_ECC,
    parameter int NUM_HANDOFF = sch_pkg::NUM_HANDOFF
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic cold_rst_i,
    input wire logic ce_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [sch_pkg::ADDR_W-1:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    output logic dma_manager_nonsecure_o,
    output logic dma_irq_nonsecure_o,
    output logic [sch_pkg::NUM_DMA_PERIPH-1:0] dma_periph_nonsecure_o,
    output logic nand_skip_init_o,
    output logic skip_first_page_load_o,
    output logic small_page_device_o,
    output logic nand_two_row_addr_o,
    output logic [2:0] flash_arprot_o,
    output logic [2:0] flash_awprot_o,
    output logic [1:0] flash_ardomain_o,
    output logic [1:0] flash_awdomain_o,
    output logic [3:0] flash_arcache_o,
    output logic [3:0] flash_awcache_o,
    output logic [NUM_EMAC-1:0] emac_ts_clk_fabric_o,
    output logic [4*NUM_EMAC-1:0] emac_arcache_o,
    output logic [4*NUM_EMAC-1:0] emac_awcache_o,
    output logic [2*NUM_EMAC-1:0] emac_phy_sel_o,
    output logic [NUM_EMAC-1:0] emac_ts_ref_ext_o,
    output logic [4*NUM_USB-1:0] usb_hprot_o,
    output logic [sch_pkg::HAUSER_W*NUM_USB-1:0] usb_hauser_o,
    output logic [3:0] card_hprot_o,
    output logic [sch_pkg::HAUSER_W-1:0] card_hauser_o,
    output logic [2:0] card_drv_phase_o,
    output logic [2:0] card_smpl_phase_o,
    input wire logic [NUM_WD-1:0] cpu_debug_i,
    output logic [NUM_WD-1:0] wd_pause_o,
    output logic [sch_pkg::NUM_FPGA_IF-1:0] fpga_if_en_o,
    input wire logic [NUM_ECC-1:0] ecc_sbe_i,
    input wire logic [NUM_ECC-1:0] ecc_dbe_i,
    output logic ecc_serr_irq_o,
    output logic ecc_derr_irq_o
);
    localparam int HW = sch_pkg::HAUSER_W;

    logic [31:0] ctrl_reg [sch_pkg::NUM_CTRL];
    logic [31:0] hand_reg [NUM_HANDOFF];
    logic ack_reg;
    logic [31:0] dat_reg;
    logic [NUM_WD-1:0] pause_reg;
    logic [NUM_ECC-1:0] sbe_status;
    logic [NUM_ECC-1:0] dbe_status;
    logic [5:0] idx;
    logic req_new;
    logic wr_stb;
    logic ctrl_hit;
    logic ho_hit;
    logic [5:0] ho_off;
    logic [31:0] rd_word;
    logic [NUM_WD-1:0] pause_next;

    // bus decode: a new request is one not yet answered
    assign idx = wb_adr_i[7:2];
    // nothing is taken while either reset stands, so a held write cannot slip in
    assign req_new = ce_i && !(rst_i || cold_rst_i) && wb_cyc_i && wb_stb_i && !ack_reg;
    assign wr_stb = req_new && wb_we_i;
    assign ctrl_hit = idx < sch_pkg::NUM_CTRL;
    assign ho_off = idx - sch_pkg::IDX_HANDOFF;
    assign ho_hit = (idx >= sch_pkg::IDX_HANDOFF) && (ho_off < 6'(NUM_HANDOFF));

    // read selection; unmapped words read zero, status words are read only
    assign rd_word = ctrl_hit ? ctrl_reg[idx[3:0]] :
                     (idx == sch_pkg::IDX_ECC_SBE) ? 32'(sbe_status) :
                     (idx == sch_pkg::IDX_ECC_DBE) ? 32'(dbe_status) :
                     ho_hit ? hand_reg[ho_off[2:0]] : 32'h0000_0000;

    // answer one cycle after the request, then drop ack for one cycle
    always_ff @(posedge clk_i) begin
        if (rst_i || cold_rst_i) begin
            ack_reg <= 1'b0;
            dat_reg <= 32'h0000_0000;
        end else if (ce_i) begin
            ack_reg <= req_new;
            if (req_new && !wb_we_i) dat_reg <= rd_word;
        end
    end
    assign wb_ack_o = ack_reg;
    assign wb_dat_o = dat_reg;

    // control words: warm or cold reset clears them; masked bits stay zero
    generate
        for (genvar i = 0; i < int'(sch_pkg::NUM_CTRL); i++) begin : g_ctrl
            always_ff @(posedge clk_i) begin
                if (rst_i || cold_rst_i) begin
                    ctrl_reg[i] <= sch_pkg::RST_WORD;
                end else if (ce_i && wr_stb && idx == 6'(i)) begin
                    ctrl_reg[i] <= sch_pkg::sch_merge(ctrl_reg[i], wb_dat_i, wb_sel_i)
                                   & sch_pkg::sch_ctrl_mask(6'(i));
                end
            end
        end
    endgenerate

    // handoff words survive warm reset; only cold reset clears them
    generate
        for (genvar h = 0; h < NUM_HANDOFF; h++) begin : g_hand
            always_ff @(posedge clk_i) begin
                if (cold_rst_i) begin
                    hand_reg[h] <= sch_pkg::RST_WORD;
                end else if (ce_i && wr_stb && ho_hit && ho_off == 6'(h)) begin
                    hand_reg[h] <= sch_pkg::sch_merge(hand_reg[h], wb_dat_i, wb_sel_i);
                end
            end
        end
    endgenerate

    // dma security; peripheral bits must be set before dma leaves reset
    assign dma_manager_nonsecure_o = ctrl_reg[0][sch_pkg::DMA_DMA_MANAGER_NONSECURE_BIT];
    assign dma_irq_nonsecure_o = ctrl_reg[0][sch_pkg::DMA_DMA_IRQ_NONSECURE_BIT];
    assign dma_periph_nonsecure_o =
        ctrl_reg[0][sch_pkg::DMA_PERIPH_LSB +: sch_pkg::NUM_DMA_PERIPH];

    // nand bootstrap: held level, the controller samples it on reset exit
    assign nand_skip_init_o = ctrl_reg[1][sch_pkg::NAND_NOINIT_BIT];
    assign skip_first_page_load_o = ctrl_reg[1][sch_pkg::NAND_SKIP_LOAD_BIT];
    assign small_page_device_o = ctrl_reg[1][sch_pkg::NAND_SMALL_PAGE_BIT];
    assign nand_two_row_addr_o = ctrl_reg[1][sch_pkg::NAND_TWO_ROW_BIT];

    // flash dma master attributes; no idle check here, software owns that
    assign flash_arprot_o = ctrl_reg[2][sch_pkg::FL_ARPROT_LSB +: 3];
    assign flash_awprot_o = ctrl_reg[2][sch_pkg::FL_AWPROT_LSB +: 3];
    assign flash_ardomain_o = ctrl_reg[2][sch_pkg::FL_ARDOM_LSB +: 2];
    assign flash_awdomain_o = ctrl_reg[2][sch_pkg::FL_AWDOM_LSB +: 2];
    assign flash_arcache_o = ctrl_reg[2][sch_pkg::FL_ARCACHE_LSB +: 4];
    assign flash_awcache_o = ctrl_reg[2][sch_pkg::FL_AWCACHE_LSB +: 4];

    // timestamp clock source: 0 clock manager, 1 fabric_timestamp_clock
    assign emac_ts_clk_fabric_o = ctrl_reg[3][NUM_EMAC-1:0];

    // per-mac words; phy select and timestamp ref are taken at mac reset exit
    generate
        for (genvar m = 0; m < NUM_EMAC; m++) begin : g_emac
            localparam int W = int'(sch_pkg::IDX_EMAC0) + m;
            assign emac_arcache_o[4*m +: 4] = ctrl_reg[W][sch_pkg::EM_ARCACHE_LSB +: 4];
            assign emac_awcache_o[4*m +: 4] = ctrl_reg[W][sch_pkg::EM_AWCACHE_LSB +: 4];
            assign emac_phy_sel_o[2*m +: 2] = ctrl_reg[W][sch_pkg::EM_PHY_LSB +: 2];
            assign emac_ts_ref_ext_o[m] = ctrl_reg[W][sch_pkg::EM_TSREF_BIT];
        end
    endgenerate

    // usb ahb master attributes, one word per controller
    generate
        for (genvar u = 0; u < NUM_USB; u++) begin : g_usb
            localparam int W = int'(sch_pkg::IDX_USB0) + u;
            assign usb_hprot_o[4*u +: 4] = ctrl_reg[W][sch_pkg::AHB_HPROT_LSB +: 4];
            assign usb_hauser_o[HW*u +: HW] = ctrl_reg[W][sch_pkg::AHB_HAUSER_LSB +: HW];
        end
    endgenerate

    // card master attributes and clock phase selects
    assign card_hprot_o = ctrl_reg[9][sch_pkg::AHB_HPROT_LSB +: 4];
    assign card_hauser_o = ctrl_reg[9][sch_pkg::AHB_HAUSER_LSB +: HW];
    assign card_drv_phase_o = ctrl_reg[10][sch_pkg::CK_DRV_LSB +: 3];
    assign card_smpl_phase_o = ctrl_reg[10][sch_pkg::CK_SMPL_LSB +: 3];

    // fpga interface enables reset to off: fabric may not be configured yet
    assign fpga_if_en_o = ctrl_reg[12][sch_pkg::NUM_FPGA_IF-1:0];

    // watchdog pause: cpu debug gated by the per-watchdog enable, registered
    assign pause_next = cpu_debug_i & ctrl_reg[11][NUM_WD-1:0];
    always_ff @(posedge clk_i) begin
        if (rst_i || cold_rst_i) begin
            pause_reg <= '0;
        end else if (ce_i) begin
            pause_reg <= pause_next;
        end
    end
    assign wd_pause_o = pause_reg;

    // ecc gathering and interrupt merge
    sch_ecc_combine #(
        .N(NUM_ECC)
    ) u_ecc (
        .clk_i(clk_i),
        .rst_i(rst_i || cold_rst_i),
        .ce_i(ce_i),
        .sbe_i(ecc_sbe_i),
        .dbe_i(ecc_dbe_i),
        .sbe_mask_i(ctrl_reg[13][NUM_ECC-1:0]),
        .sbe_status_o(sbe_status),
        .dbe_status_o(dbe_status),
        .serr_irq_o(ecc_serr_irq_o),
        .derr_irq_o(ecc_derr_irq_o)
    );

    // ---- checks ----
    sequence s_req;
        ce_i && wb_cyc_i && wb_stb_i && !wb_ack_o;
    endsequence

    sequence s_ack_once;
        wb_ack_o ##1 !wb_ack_o;
    endsequence

    AST_ACK_ONE_CYCLE: assert property (
        @(posedge clk_i) disable iff (rst_i || cold_rst_i)
        s_req ##1 ce_i |-> s_ack_once)
        else $error("ack not a single cycle after request");

    AST_UNMAPPED_ZERO: assert property (
        @(posedge clk_i) disable iff (rst_i || cold_rst_i)
        (s_req and (!wb_we_i && !ctrl_hit && !ho_hit
                    && idx != sch_pkg::IDX_ECC_SBE && idx != sch_pkg::IDX_ECC_DBE))
        |=> wb_dat_o == 32'h0000_0000)
        else $error("unmapped read not zero");

    AST_DMA_WRITE: assert property (
        @(posedge clk_i) disable iff (rst_i || cold_rst_i)
        (s_req and (wb_we_i && idx == sch_pkg::IDX_DMA && wb_sel_i[0]))
        |=> dma_manager_nonsecure_o == $past(wb_dat_i[sch_pkg::DMA_DMA_MANAGER_NONSECURE_BIT]))
        else $error("dma manager security not written");

    AST_NAND_HELD: assert property (
        @(posedge clk_i) disable iff (rst_i || cold_rst_i)
        !(wr_stb && idx == sch_pkg::IDX_NAND_BOOT)
        |=> $stable(small_page_device_o) && $stable(nand_skip_init_o))
        else $error("bootstrap bit changed without a write");

    AST_WD_PAUSE: assert property (
        @(posedge clk_i) disable iff (rst_i || cold_rst_i)
        (ce_i && cpu_debug_i[0] && ctrl_reg[11][0]) ##1 ce_i
        |-> wd_pause_o[0] ##1 (wd_pause_o[0] == $past(pause_next[0])))
        else $error("watchdog pause does not follow debug");

    AST_DERR_UNMASKED: assert property (
        @(posedge clk_i) disable iff (rst_i || cold_rst_i)
        (ce_i && ecc_dbe_i != '0) |=> ecc_derr_irq_o)
        else $error("double-bit error interrupt missing");

    AST_SERR_MASKED: assert property (
        @(posedge clk_i) disable iff (rst_i || cold_rst_i)
        (ce_i && (ecc_sbe_i & ~ctrl_reg[13][NUM_ECC-1:0]) == '0) |=> !ecc_serr_irq_o)
        else $error("masked single-bit error raised interrupt");

    AST_STATUS_FOLLOWS: assert property (
        @(posedge clk_i) disable iff (rst_i || cold_rst_i)
        ce_i |=> sbe_status == $past(ecc_sbe_i) && dbe_status == $past(ecc_dbe_i))
        else $error("ecc status does not follow sources");

    AST_HANDOFF_WARM: assert property (
        @(posedge clk_i)
        (rst_i && !cold_rst_i) |=> $stable(hand_reg[0]))
        else $error("handoff word changed on warm reset");

    AST_COLD_CLEAR: assert property (
        @(posedge clk_i)
        cold_rst_i |=> hand_reg[0] == 32'h0000_0000 && ctrl_reg[0] == 32'h0000_0000
                       && !wb_ack_o)
        else $error("cold reset did not clear fields");

endmodule // sch_top

// ==== testbench/sch_src_model.sv ====
// behavioural model of the ecc-protected ram sources and of cpu debug status.
// assumes the bench changes its commands right after a rising clk_i edge.
module sch_src_model (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic [sch_pkg::NUM_ECC-1:0] sbe_set_i,
    input wire logic [sch_pkg::NUM_ECC-1:0] dbe_set_i,
    input wire logic [sch_pkg::NUM_ECC-1:0] clr_i,
    input wire logic [sch_pkg::NUM_WD-1:0] dbg_i,
    output logic [sch_pkg::NUM_ECC-1:0] ecc_sbe_o,
    output logic [sch_pkg::NUM_ECC-1:0] ecc_dbe_o,
    output logic [sch_pkg::NUM_WD-1:0] cpu_debug_o
);
    timeunit 1ns;
    timeprecision 100ps;
    // an error level holds until cleared at its source, so the hub cannot lean on pulses
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ecc_sbe_o <= '0;
            ecc_dbe_o <= '0;
            cpu_debug_o <= '0;
        end else begin
            ecc_sbe_o <= (ecc_sbe_o | sbe_set_i) & ~clr_i;
            ecc_dbe_o <= (ecc_dbe_o | dbe_set_i) & ~clr_i;
            cpu_debug_o <= dbg_i;
        end
    end
endmodule // sch_src_model

// ==== testbench/test_system_control_status_hub.sv ====
// self-checking bench of the hub: wishbone register accesses, side-band levels,
// ecc combining, watchdog pause and the two resets.
// assumes sch_pkg, sch_top and sch_src_model are compiled before it.
module test_system_control_status_hub;
    timeunit 1ns;
    timeprecision 100ps;
    logic clk_i, rst_i, cold_rst_i, ce_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
    logic dma_manager_nonsecure_o, dma_irq_nonsecure_o, nand_skip_init_o;
    logic skip_first_page_load_o, small_page_device_o, nand_two_row_addr_o;
    logic ecc_serr_irq_o, ecc_derr_irq_o;
    logic [7:0] wb_adr_i, dma_periph_nonsecure_o, usb_hprot_o;
    logic [3:0] wb_sel_i, cpu_debug_i, wd_pause_o, dbg_cmd;
    logic [31:0] wb_dat_i, wb_dat_o, rd;
    logic [2:0] flash_arprot_o, flash_awprot_o, card_drv_phase_o, card_smpl_phase_o;
    logic [2:0] emac_ts_clk_fabric_o, emac_ts_ref_ext_o;
    logic [1:0] flash_ardomain_o, flash_awdomain_o;
    logic [3:0] flash_arcache_o, flash_awcache_o, card_hprot_o;
    logic [11:0] emac_arcache_o, emac_awcache_o;
    logic [5:0] emac_phy_sel_o;
    logic [9:0] usb_hauser_o;
    logic [4:0] card_hauser_o;
    logic [8:0] fpga_if_en_o;
    logic [10:0] ecc_sbe_i, ecc_dbe_i, sbe_set, dbe_set, err_clr;
    logic [31:0] msk [14];
    logic [31:0] e [14];
    int failures, n_compared, cycles;

    sch_top DUT (.clk_i, .rst_i, .cold_rst_i, .ce_i, .wb_cyc_i, .wb_stb_i, .wb_we_i,
        .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .dma_manager_nonsecure_o,
        .dma_irq_nonsecure_o, .dma_periph_nonsecure_o, .nand_skip_init_o,
        .skip_first_page_load_o, .small_page_device_o, .nand_two_row_addr_o,
        .flash_arprot_o, .flash_awprot_o, .flash_ardomain_o, .flash_awdomain_o,
        .flash_arcache_o, .flash_awcache_o, .emac_ts_clk_fabric_o, .emac_arcache_o,
        .emac_awcache_o, .emac_phy_sel_o, .emac_ts_ref_ext_o, .usb_hprot_o, .usb_hauser_o,
        .card_hprot_o, .card_hauser_o, .card_drv_phase_o, .card_smpl_phase_o,
        .cpu_debug_i, .wd_pause_o, .fpga_if_en_o, .ecc_sbe_i, .ecc_dbe_i,
        .ecc_serr_irq_o, .ecc_derr_irq_o);

    sch_src_model MODEL (.clk_i, .rst_i, .sbe_set_i(sbe_set), .dbe_set_i(dbe_set),
        .clr_i(err_clr), .dbg_i(dbg_cmd), .ecc_sbe_o(ecc_sbe_i), .ecc_dbe_o(ecc_dbe_i),
        .cpu_debug_o(cpu_debug_i));

    // free-running 250 MHz clock
    initial begin
        clk_i = 1'h0;
        forever #2 clk_i = ~clk_i;
    end

    // hang guard: the whole sequence needs well under a thousand cycles
    always @(posedge clk_i) begin
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            failures++;
            give_verdict();
        end
    end

    task automatic give_verdict();
        $display("compared %0d mismatches %0d", n_compared, failures);
        if (failures == 0 && n_compared > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_compared++;
        if (got !== exp) begin
            failures++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask

    // one classic cycle; request held until ack is sampled high, then released
    task automatic wb_xfer(input logic we, input logic [7:0] a, input logic [31:0] d,
                           input logic [3:0] s);
        int n;
        @(posedge clk_i);
        wb_cyc_i <= 1'h1;
        wb_stb_i <= 1'h1;
        wb_we_i <= we;
        wb_adr_i <= a;
        wb_dat_i <= d;
        wb_sel_i <= s;
        n = 0;
        do begin
            @(posedge clk_i);
            n++;
        end while (wb_ack_o !== 1'h1 && n < 100);
        rd = wb_dat_o;
        if (n >= 100) failures++;
        wb_cyc_i <= 1'h0;
        wb_stb_i <= 1'h0;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        wb_xfer(1'h1, a, d, 4'hF);
    endtask

    task automatic rd_chk(input string what, input logic [7:0] a, input logic [31:0] exp);
        wb_xfer(1'h0, a, 32'h0000_0000, 4'hF);
        chk(what, exp, rd);
    endtask

    // source events last one cycle in the model, then two edges for the hub to follow
    task automatic err(input logic [10:0] sb, input logic [10:0] db, input logic [10:0] cl);
        @(posedge clk_i);
        sbe_set <= sb;
        dbe_set <= db;
        err_clr <= cl;
        @(posedge clk_i);
        sbe_set <= 11'h000;
        dbe_set <= 11'h000;
        err_clr <= 11'h000;
        repeat (2) @(posedge clk_i);
    endtask

    task automatic pulse_reset(input logic cold);
        @(posedge clk_i);
        rst_i <= 1'h1;
        cold_rst_i <= cold;
        repeat (2) @(posedge clk_i);
        rst_i <= 1'h0;
        cold_rst_i <= 1'h0;
    endtask

    // side-band outputs packed back into the layout of their control word
    function automatic logic [31:0] side_word(input int i);
        int m;
        m = (i >= 7) ? i - 7 : i - 4;
        case (i)
            0: return {16'h0, dma_periph_nonsecure_o, 6'h0, dma_irq_nonsecure_o,
                       dma_manager_nonsecure_o};
            1: return {28'h0, nand_two_row_addr_o, small_page_device_o,
                       skip_first_page_load_o, nand_skip_init_o};
            2: return {14'h0, flash_awcache_o, flash_arcache_o, flash_awdomain_o,
                       flash_ardomain_o, flash_awprot_o, flash_arprot_o};
            3: return {29'h0, emac_ts_clk_fabric_o};
            4, 5, 6: return {21'h0, emac_ts_ref_ext_o[m], emac_phy_sel_o[2*m +: 2],
                             emac_awcache_o[4*m +: 4], emac_arcache_o[4*m +: 4]};
            7, 8: return {23'h0, usb_hauser_o[5*m +: 5], usb_hprot_o[4*m +: 4]};
            9: return {23'h0, card_hauser_o, card_hprot_o};
            10: return {25'h0, card_smpl_phase_o, 1'h0, card_drv_phase_o};
            default: return {23'h0, fpga_if_en_o};
        endcase
    endfunction

    // main sequence
    initial begin
        {rst_i, cold_rst_i, ce_i} = 3'h7;
        {wb_cyc_i, wb_stb_i, wb_we_i} = 3'h0;
        wb_adr_i = 8'h00;
        wb_sel_i = 4'h0;
        wb_dat_i = 32'h0000_0000;
        {sbe_set, dbe_set, err_clr, dbg_cmd} = '0;
        {failures, n_compared, cycles} = '0;
        msk = '{sch_pkg::MASK_DMA, sch_pkg::MASK_NAND, sch_pkg::MASK_FLASH,
                sch_pkg::MASK_EGLOB, sch_pkg::MASK_EMAC, sch_pkg::MASK_EMAC,
                sch_pkg::MASK_EMAC, sch_pkg::MASK_AHB, sch_pkg::MASK_AHB, sch_pkg::MASK_AHB,
                sch_pkg::MASK_CLK, sch_pkg::MASK_WD, sch_pkg::MASK_FPGA, sch_pkg::MASK_ECC};
        repeat (6) @(posedge clk_i);
        rst_i <= 1'h0;
        cold_rst_i <= 1'h0;
        for (int i = 0; i < 14; i++) rd_chk("reset word", 8'(4*i), 32'h0000_0000);
        for (int i = 0; i < 14; i++) begin
            e[i] = (32'hA5C3_96E1 ^ {8{4'(3*i)}}) & msk[i];
            wr(8'(4*i), 32'hA5C3_96E1 ^ {8{4'(3*i)}});
            rd_chk("word readback", 8'(4*i), e[i]);
        end
        for (int i = 0; i < 4; i++) chk("side", e[i], side_word(i));
        for (int i = 4; i < 11; i++) chk("side", e[i], side_word(i));
        chk("fpga enables", e[12], side_word(12));
        wb_xfer(1'h1, 8'h08, 32'hFFFF_FFFF, 4'h2);
        rd_chk("byte lane", 8'h08, (e[2] | 32'h0000_FF00) & msk[2]);
        wr(8'h40, 32'hFFFF_FFFF);
        rd_chk("unmapped", 8'h40, 32'h0000_0000);
        wr(8'h38, 32'hFFFF_FFFF);
        rd_chk("sbe status", 8'h38, 32'h0000_0000);
        wr(8'h34, 32'h0000_0001);
        err(11'h001, 11'h000, 11'h000);
        chk("serr masked", 32'h0, {31'h0, ecc_serr_irq_o});
        rd_chk("sbe status", 8'h38, 32'h0000_0001);
        err(11'h008, 11'h000, 11'h000);
        chk("serr open", 32'h1, {31'h0, ecc_serr_irq_o});
        err(11'h000, 11'h001, 11'h000);
        chk("derr", 32'h1, {31'h0, ecc_derr_irq_o});
        rd_chk("dbe status", 8'h3C, 32'h0000_0001);
        err(11'h000, 11'h000, 11'h7FF);
        chk("irqs cleared", 32'h0, {30'h0, ecc_derr_irq_o, ecc_serr_irq_o});
        rd_chk("sbe status", 8'h38, 32'h0000_0000);
        wr(8'h2C, 32'h0000_0005);
        // clock enable low freezes the pause register although debug rises
        ce_i <= 1'h0;
        dbg_cmd <= 4'hF;
        repeat (3) @(posedge clk_i);
        chk("wd pause frozen", 32'h0, {28'h0, wd_pause_o});
        ce_i <= 1'h1;
        repeat (2) @(posedge clk_i);
        chk("wd pause", 32'h5, {28'h0, wd_pause_o});
        dbg_cmd <= 4'h0;
        repeat (3) @(posedge clk_i);
        chk("wd pause off", 32'h0, {28'h0, wd_pause_o});
        for (int k = 0; k < 8; k++) wr(8'(8'h80 + 4*k), 32'hC0DE_0000 | 32'(k));
        pulse_reset(1'h0);
        rd_chk("handoff warm", 8'h8C, 32'hC0DE_0003);
        rd_chk("dma warm", 8'h00, 32'h0000_0000);
        chk("fpga warm", 32'h0, {23'h0, fpga_if_en_o});
        pulse_reset(1'h1);
        rd_chk("handoff cold", 8'h8C, 32'h0000_0000);
        give_verdict();
    end
endmodule // test_system_control_status_hub
